// ### rtl/tsx_exec.sv
// Executor for test-skip-zero, xor-immediate and table-write instructions
`timescale 1ns/100ps
`include "tsx_cfg.svh"
module tsx_exec
    import tsx_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [1:0] Q_PHASE,
    input wire logic [15:0] INSTR,
    input wire logic NEXT_TWO_WORD,
    input wire logic EXT_SET_EN,
    input wire logic [3:0] BANK_SELECT_REG,
    input wire logic [7:0] FSR2_BASE,
    input wire tsx_byte_t FILE_RDATA,
    input wire tsx_byte_t TABLE_LATCH,
    input wire logic PTR_LOAD,
    input wire logic [`TSX_PTR_W-1:0] PTR_LOAD_VAL,
    input wire logic [2:0] HOLD_RD_ADDR,
    output logic [11:0] FILE_ADDR,
    output logic IS_NOP,
    output logic SKIP_ACTIVE,
    output tsx_byte_t WREG,
    output logic FLAG_N,
    output logic FLAG_Z,
    output logic [`TSX_PTR_W-1:0] PROGRAM_MEMORY_POINTER,
    output tsx_byte_t HOLD_RDATA
);
    tsx_state_t state_ff, nxt_state;
    tsx_byte_t w_ff, nxt_w;
    logic n_ff, nxt_n, z_ff, nxt_z;
    logic [`TSX_PTR_W-1:0] ptr_ff, nxt_ptr;
    logic [11:0] addr_ff, nxt_addr;
    logic hold_we;
    logic [2:0] hold_wa;
    logic cyc_end, is_tst, is_xor, is_tblw, access_a, indexed;
    tsx_byte_t xor_res;
    logic [7:0] idx_sum;

    assign cyc_end = (Q_PHASE == `TSX_Q_LAST);
    assign is_tst = (INSTR[15:9] == `TSX_OPC_TSTSZ);
    assign is_xor = (INSTR[15:8] == `TSX_OPC_XORI);
    assign is_tblw = (INSTR[15:2] == `TSX_OPC_TBLW);
    assign access_a = INSTR[8];
    assign indexed = !access_a && EXT_SET_EN && (INSTR[7:0] <= `TSX_IDX_LIMIT);
    assign xor_res = w_ff ^ INSTR[7:0];
    assign idx_sum = FSR2_BASE + INSTR[7:0];

    always_comb begin
        nxt_addr = addr_ff;
        if (state_ff == TSX_EXEC && is_tst) begin
            if (indexed) begin
                nxt_addr = {4'h0, idx_sum};
            end else if (!access_a) begin
                // Access bank: 00h-5Fh is bank 0, 60h-FFh the special regs
                nxt_addr = (INSTR[7:0] < `TSX_ACC_SPLIT) ? {4'h0, INSTR[7:0]}
                    : {`TSX_SFR_BANK, INSTR[7:0]};
            end else begin
                nxt_addr = {BANK_SELECT_REG, INSTR[7:0]};
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_w = w_ff;
        nxt_n = n_ff;
        nxt_z = z_ff;
        nxt_ptr = ptr_ff;
        hold_we = 1'b0;
        hold_wa = ptr_ff[2:0];
        if (PTR_LOAD) begin
            nxt_ptr = PTR_LOAD_VAL;
        end
        if (cyc_end) begin
            unique case (state_ff)
                TSX_EXEC: begin
                    if (is_tst && FILE_RDATA == 8'h00) begin
                        nxt_state = TSX_SKIP;
                    end else if (is_xor) begin
                        nxt_w = xor_res;
                        nxt_n = xor_res[7];
                        nxt_z = (xor_res == 8'h00);
                    end else if (is_tblw && INSTR[1:0] == `TSX_TBLW_POST) begin
                        hold_we = 1'b1;
                        hold_wa = ptr_ff[2:0];
                        nxt_ptr = ptr_ff + 1'b1;
                    end else if (is_tblw && INSTR[1:0] == `TSX_TBLW_PRE) begin
                        nxt_ptr = ptr_ff + 1'b1;
                        hold_we = 1'b1;
                        hold_wa = nxt_ptr[2:0];
                    end else if (is_tblw) begin
                        hold_we = 1'b1;
                        hold_wa = ptr_ff[2:0];
                        if (INSTR[1:0] == 2'h2) begin
                            nxt_ptr = ptr_ff - 1'b1;
                        end
                    end
                end
                TSX_SKIP: begin
                    // Two-word victim needs its second word flushed too
                    nxt_state = NEXT_TWO_WORD ? TSX_SKIP2 : TSX_EXEC;
                end
                TSX_SKIP2: begin
                    nxt_state = TSX_EXEC;
                end
                default: begin
                    nxt_state = TSX_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_ff <= TSX_EXEC;
            w_ff <= 8'h00;
            n_ff <= 1'b0;
            z_ff <= 1'b0;
            ptr_ff <= '0;
            addr_ff <= 12'h000;
        end else begin
            state_ff <= nxt_state;
            w_ff <= nxt_w;
            n_ff <= nxt_n;
            z_ff <= nxt_z;
            ptr_ff <= nxt_ptr;
            addr_ff <= nxt_addr;
        end
    end

    tsx_hold_mem u_hold (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .wr_en(hold_we),
        .wr_addr(hold_wa),
        .wr_data(TABLE_LATCH),
        .rd_addr(HOLD_RD_ADDR),
        .rd_data(HOLD_RDATA)
    );

    assign FILE_ADDR = addr_ff;
    assign IS_NOP = (state_ff != TSX_EXEC);
    assign SKIP_ACTIVE = (state_ff != TSX_EXEC);
    assign WREG = w_ff;
    assign FLAG_N = n_ff;
    assign FLAG_Z = z_ff;
    assign PROGRAM_MEMORY_POINTER = ptr_ff;

    sequence s_skip_start;
        state_ff == TSX_EXEC && cyc_end && is_tst && FILE_RDATA == 8'h00;
    endsequence

    AST_SKIP_ENTER: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_skip_start |=> state_ff == TSX_SKIP)
        else $error("zero test did not start skip");
    AST_SKIP_TWO: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == TSX_SKIP && cyc_end && NEXT_TWO_WORD |=> state_ff == TSX_SKIP2)
        else $error("two-word skip missed extra cycle");
    AST_SKIP_ONE: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == TSX_SKIP && cyc_end && !NEXT_TWO_WORD |=> state_ff == TSX_EXEC)
        else $error("one-word skip too long");
    AST_BANK: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == TSX_EXEC && is_tst && access_a
        |=> FILE_ADDR == {$past(BANK_SELECT_REG), $past(INSTR[7:0])})
        else $error("banked address wrong");
    AST_INDEXED: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == TSX_EXEC && is_tst && indexed |=> FILE_ADDR[11:8] == 4'h0)
        else $error("indexed address wrong");
    AST_XOR: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == TSX_EXEC && cyc_end && is_xor
        |=> WREG == ($past(WREG) ^ $past(INSTR[7:0])) && FLAG_Z == (WREG == 8'h00)
        && FLAG_N == WREG[7])
        else $error("xor result or flags wrong");
    AST_POST_INC: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == TSX_EXEC && cyc_end && is_tblw && INSTR[1:0] == `TSX_TBLW_POST
        && !PTR_LOAD |-> hold_we && hold_wa == ptr_ff[2:0] ##1 ptr_ff == $past(ptr_ff) + 1'b1)
        else $error("post-increment write wrong");
    AST_PRE_INC: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == TSX_EXEC && cyc_end && is_tblw && INSTR[1:0] == `TSX_TBLW_PRE
        |-> hold_we && hold_wa == 3'(ptr_ff + 1'b1))
        else $error("pre-increment write wrong");
    AST_TST_QUIET: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        state_ff == TSX_EXEC && is_tst |=> $stable(WREG) && $stable(FLAG_N)
        && $stable(FLAG_Z))
        else $error("test-skip changed state");
endmodule

// ### rtl/tsx_cfg.svh
// Constants for the test-skip, xor-immediate and table-write executor
`ifndef TSX_CFG_SVH
`define TSX_CFG_SVH
`define TSX_OPC_TSTSZ 7'h33
`define TSX_OPC_XORI 8'h0A
`define TSX_OPC_TBLW 14'h0003
`define TSX_TBLW_POST 2'h1
`define TSX_TBLW_PRE 2'h3
`define TSX_IDX_LIMIT 8'h5F
`define TSX_ACC_SPLIT 8'h60
`define TSX_SFR_BANK 4'hF
`define TSX_PTR_W 21
`define TSX_HOLD_N 8
`define TSX_Q_LAST 2'h3
`endif

// ### rtl/tsx_pkg.sv
// Types for the test-skip, xor-immediate and table-write executor
package tsx_pkg;
    typedef enum logic [1:0] {
        TSX_EXEC = 2'b00,
        TSX_SKIP = 2'b01,
        TSX_SKIP2 = 2'b10
    } tsx_state_t;
    typedef logic [7:0] tsx_byte_t;
endpackage

// ### rtl/tsx_hold_mem.sv
// Eight byte program-memory holding registers with registered read
`timescale 1ns/100ps
`include "tsx_cfg.svh"
module tsx_hold_mem
    import tsx_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire tsx_byte_t wr_data,
    input wire logic [2:0] rd_addr,
    output tsx_byte_t rd_data
);
    tsx_byte_t mem_ff [`TSX_HOLD_N];
    tsx_byte_t nxt_mem [`TSX_HOLD_N];
    tsx_byte_t rd_ff;

    always_comb begin
        nxt_mem = mem_ff;
        if (wr_en) begin
            nxt_mem[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `TSX_HOLD_N; i++) begin
                mem_ff[i] <= 8'hFF;
            end
            rd_ff <= 8'h00;
        end else begin
            mem_ff <= nxt_mem;
            rd_ff <= mem_ff[rd_addr];
        end
    end

    assign rd_data = rd_ff;
endmodule

// ### tb/tsx_exec_tb.sv
// Self-checking bench for the test-skip, xor-immediate and table-write executor
`timescale 1ns/100ps
module tsx_exec_tb;
    import tsx_pkg::*;
    typedef struct {
        logic [15:0] ins;
        logic ext;
        logic [3:0] bank_select_reg;
        tsx_byte_t w;
        logic n;
        logic z;
        logic [11:0] adr;
    } tsx_row_t;
    logic clk_sys, sys_rst, next_two_word, ext_set_en, ptr_load, is_nop, flag_n, flag_z;
    logic skip_active;
    logic [1:0] q_phase;
    logic [15:0] instr;
    logic [3:0] bank_select_reg;
    tsx_byte_t file_rdata, table_latch, wreg, hold_rdata;
    logic [20:0] ptr_load_val, pmp;
    logic [2:0] hold_rd_addr;
    logic [11:0] file_addr;
    int errors, samples_checked, nop_cnt, base;
    tsx_row_t rows [10];

    tsx_exec uut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .Q_PHASE(q_phase), .INSTR(instr),
        .NEXT_TWO_WORD(next_two_word), .EXT_SET_EN(ext_set_en), .BANK_SELECT_REG(bank_select_reg),
        .FSR2_BASE(8'h20), .FILE_RDATA(file_rdata), .TABLE_LATCH(table_latch),
        .PTR_LOAD(ptr_load), .PTR_LOAD_VAL(ptr_load_val), .HOLD_RD_ADDR(hold_rd_addr),
        .FILE_ADDR(file_addr), .IS_NOP(is_nop), .SKIP_ACTIVE(skip_active), .WREG(wreg),
        .FLAG_N(flag_n), .FLAG_Z(flag_z), .PROGRAM_MEMORY_POINTER(pmp),
        .HOLD_RDATA(hold_rdata));

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Free-running phase, so back-to-back cycles need no handshake
    always @(posedge clk_sys) q_phase <= sys_rst ? 2'h0 : q_phase + 2'h1;
    always @(posedge clk_sys) nop_cnt <= nop_cnt + int'(is_nop === 1'h1);

    task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("Comparisons %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Follower word is what the core fetched behind ins; it replaces ins four clocks later, for the next instruction cycle
    task automatic run(input logic [15:0] ins, input logic [15:0] fol = 16'h0000);
        int i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (q_phase !== 2'h3 && i < 9);
        if (q_phase !== 2'h3) begin
            errors++;
            end_sim();
        end
        instr <= ins;
        repeat (4) @(posedge clk_sys);
        instr <= fol;
        #1;
    endtask
    task automatic hold_chk(input logic [2:0] a, input tsx_byte_t e);
        @(posedge clk_sys);
        hold_rd_addr <= a;
        @(posedge clk_sys);
        #1;
        chk("hold", 21'(e), 21'(hold_rdata));
    endtask
    task automatic twr(input logic [20:0] p, input tsx_byte_t l, input logic [15:0] ins);
        @(posedge clk_sys);
        ptr_load <= 1'h1;
        ptr_load_val <= p;
        table_latch <= l;
        @(posedge clk_sys);
        ptr_load <= 1'h0;
        run(ins);
    endtask

    initial begin
        sys_rst = 1'h1;
        instr = 16'h0000;
        next_two_word = 1'h0;
        ext_set_en = 1'h0;
        ptr_load = 1'h0;
        bank_select_reg = 4'h0;
        file_rdata = 8'hFF;
        table_latch = 8'h00;
        ptr_load_val = 21'h0;
        hold_rd_addr = 3'h2;
        rows = '{'{16'h0AB5, 1'h0, 4'h0, 8'hB5, 1'h1, 1'h0, 12'h000},
            '{16'h6710, 1'h1, 4'h5, 8'hB5, 1'h1, 1'h0, 12'h510},
            '{16'h0AAF, 1'h0, 4'h5, 8'h1A, 1'h0, 1'h0, 12'h000},
            '{16'h665F, 1'h0, 4'h5, 8'h1A, 1'h0, 1'h0, 12'h05F},
            '{16'h6660, 1'h0, 4'h5, 8'h1A, 1'h0, 1'h0, 12'hF60},
            '{16'h0A1A, 1'h0, 4'h5, 8'h00, 1'h0, 1'h1, 12'h000},
            '{16'h665F, 1'h1, 4'h5, 8'h00, 1'h0, 1'h1, 12'h07F},
            '{16'h6660, 1'h1, 4'h5, 8'h00, 1'h0, 1'h1, 12'hF60},
            '{16'h0A80, 1'h1, 4'h5, 8'h80, 1'h1, 1'h0, 12'h000},
            '{16'h6600, 1'h1, 4'h5, 8'h80, 1'h1, 1'h0, 12'h020}};
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'h0;
        #1;
        chk("wreg_nz", 21'h0, 21'({wreg, flag_n, flag_z}));
        chk("rst_misc", 21'h0, 21'({file_addr, is_nop, hold_rdata}));
        chk("pointer", 21'h0, pmp);
        hold_chk(3'h2, 8'hFF);
        foreach (rows[r]) begin
            @(posedge clk_sys);
            ext_set_en <= rows[r].ext;
            bank_select_reg <= rows[r].bank_select_reg;
            run(rows[r].ins);
            chk("wreg_nz", 21'({rows[r].w, rows[r].n, rows[r].z}), 21'({wreg, flag_n, flag_z}));
            if (rows[r].ins[15:9] == 7'h33) chk("file_addr", 21'(rows[r].adr), 21'(file_addr));
        end
        twr(21'h00A356, 8'h55, 16'h000D);
        chk("pointer", 21'h00A357, pmp);
        twr(21'h01389A, 8'h34, 16'h000F);
        chk("pointer", 21'h01389B, pmp);
        twr(21'h0000FF, 8'hA5, 16'h000F);
        chk("pointer", 21'h000100, pmp);
        hold_chk(3'h6, 8'h55);
        hold_chk(3'h3, 8'h34);
        hold_chk(3'h2, 8'hFF);
        hold_chk(3'h0, 8'hA5);
        // Xor behind a taken skip must not land
        @(posedge clk_sys);
        file_rdata <= 8'h00;
        base = nop_cnt;
        run(16'h6710, 16'h0AFF);
        chk("skip_active", 21'h1, 21'(skip_active));
        run(16'h0000);
        chk("nop_cycles", 21'h4, 21'(nop_cnt - base));
        chk("wreg", 21'h80, 21'(wreg));
        chk("skip_active", 21'h0, 21'(skip_active));
        @(posedge clk_sys);
        next_two_word <= 1'h1;
        base = nop_cnt;
        run(16'h6710, 16'h0AFF);
        run(16'h0000);
        run(16'h0000);
        chk("nop_cycles", 21'h8, 21'(nop_cnt - base));
        chk("wreg", 21'h80, 21'(wreg));
        @(posedge clk_sys);
        next_two_word <= 1'h0;
        file_rdata <= 8'h01;
        base = nop_cnt;
        run(16'h6710, 16'h0A0F);
        run(16'h0000);
        chk("nop_cycles", 21'h0, 21'(nop_cnt - base));
        chk("wreg_nz", 21'({8'h8F, 2'h2}), 21'({wreg, flag_n, flag_z}));
        @(posedge clk_sys);
        sys_rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("wreg_nz", 21'h0, 21'({wreg, flag_n, flag_z}));
        chk("pointer", 21'h0, pmp);
        end_sim();
    end
endmodule
